// >>> lcd_segment_driver_control.sv
module lcd_segment_driver_control import lcd_drv_pkg::*; (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [11:0] axi_awaddr_i,
  input wire logic axi_awvalid_i,
  output logic axi_awready_o,
  input wire logic [31:0] axi_wdata_i,
  input wire logic [3:0] axi_wstrb_i,
  input wire logic axi_wvalid_i,
  output logic axi_wready_o,
  output logic [1:0] axi_bresp_o,
  output logic axi_bvalid_o,
  input wire logic axi_bready_i,
  input wire logic [11:0] axi_araddr_i,
  input wire logic axi_arvalid_i,
  output logic axi_arready_o,
  output logic [31:0] axi_rdata_o,
  output logic [1:0] axi_rresp_o,
  output logic axi_rvalid_o,
  input wire logic axi_rready_i,
  input wire logic idle_mode_i,
  input wire logic sleep_mode_i,
  input wire logic fast_rc_osc_i,
  input wire logic slow_rc_osc_i,
  input wire logic crystal_osc_32k_i,
  output logic [15:0] backplane_line_o,
  output logic [127:0] frontplane_line_o,
  output logic [63:0] glyph_pin_enable_o,
  output logic [1:0] bias_mode_o,
  output logic pump_enable_o,
  output logic [2:0] regulator_level_o,
  output logic third_bias_support_o,
  output logic [1:0] regulator_clock_select_o,
  output logic regulator_enable_o,
  output logic driver_active_o
);
  typedef struct packed {
    logic aw_full;
    logic [11:0] aw_addr;
    logic w_full;
    logic [15:0] w_data;
    logic [1:0] w_be;
    logic b_valid;
    logic [1:0] b_resp;
    logic ar_busy;
    logic [11:0] ar_addr;
    logic r_valid;
    logic [31:0] r_data;
    logic [1:0] r_resp;
    logic [15:0] control;
    logic [15:0] pump;
    logic [15:0] phase_cfg;
    logic [3:0][15:0] seg_en;
    logic fail;
    logic [2:0][2:0] src_sync;
    logic [2:0] src_lvl;
    logic [3:0] pre_cnt;
    logic step;
    logic [2:0] backplane_line;
    logic phase;
    logic active;
    logic [7:0][1:0] com_lvl;
    logic [63:0][1:0] seg_lvl;
    logic [63:0] pins;
    bias_type bias;
    logic reg_on;
  } state_type;

  state_type st_q;
  state_type st_d;
  logic ram_we;
  logic [15:0] ram_word;
  logic [63:0] ram_row;
  logic set_fail;
  logic clr_fail;
  logic allow;
  logic [2:0] mux;

  function automatic logic [1:0] top_of(bias_type b);
    return (b == BIAS_THIRD) ? LVL_TOP : (b == BIAS_HALF) ? LVL_TWO : LVL_ONE;
  endfunction

  function automatic logic [1:0] com_level(bias_type b, logic sel, logic ph);
    if (sel) return ph ? top_of(b) : LVL_GND;
    return (b == BIAS_THIRD) ? (ph ? LVL_ONE : LVL_TWO) : LVL_ONE;
  endfunction

  function automatic logic [1:0] seg_level(bias_type b, logic on, logic ph);
    if (on) return ph ? LVL_GND : top_of(b);
    if (b == BIAS_THIRD) return ph ? LVL_TWO : LVL_ONE;
    return ph ? top_of(b) : LVL_GND;
  endfunction

  function automatic logic [15:0] merge(logic [15:0] old, logic [15:0] mask,
                                        logic [15:0] data, logic [1:0] be);
    logic [15:0] m;
    m = {{BYTE_W{be[1]}}, {BYTE_W{be[0]}}} & mask;
    return (old & ~m) | (data & m);
  endfunction

  assign mux = st_q.control[MUX_LSB +: 3];
  // Pixel updates are safe while idle or during the first interval of a frame
  assign allow = !st_q.active || (st_q.backplane_line == 3'h0 && !st_q.phase);

  always_comb begin
    logic [2:0] edges;
    logic tick;
    logic run;
    logic wrap;
    area_type wa;
    area_type ra;
    edges = '0;
    tick = 1'b0;
    run = 1'b0;
    wrap = 1'b0;
    wa = area_of(st_q.aw_addr);
    ra = area_of(st_q.ar_addr);
    st_d = st_q;
    ram_we = 1'b0;
    set_fail = 1'b0;
    clr_fail = 1'b0;

    if (axi_awvalid_i && axi_awready_o) begin
      st_d.aw_full = 1'b1;
      st_d.aw_addr = axi_awaddr_i;
    end
    if (axi_wvalid_i && axi_wready_o) begin
      st_d.w_full = 1'b1;
      st_d.w_data = axi_wdata_i[15:0];
      st_d.w_be = axi_wstrb_i[1:0];
    end
    if (st_q.b_valid && axi_bready_i) begin
      st_d.b_valid = 1'b0;
    end
    if (st_q.aw_full && st_q.w_full && !st_q.b_valid) begin
      st_d.aw_full = 1'b0;
      st_d.w_full = 1'b0;
      st_d.b_valid = 1'b1;
      st_d.b_resp = (wa == AREA_NONE) ? RESP_SLVERR : RESP_OKAY;
      case (wa)
        AREA_CONTROL: begin
          st_d.control = merge(st_q.control, CONTROL_MASK, st_q.w_data, st_q.w_be);
          clr_fail = st_q.w_be[0] && !st_q.w_data[FAIL_BIT];
        end
        AREA_PUMP: begin
          st_d.pump = merge(st_q.pump, PUMP_MASK, st_q.w_data, st_q.w_be);
        end
        AREA_PHASE: begin
          st_d.phase_cfg = merge(st_q.phase_cfg, PHASE_MASK, st_q.w_data, st_q.w_be);
        end
        AREA_SEG: begin
          st_d.seg_en[st_q.aw_addr[3:2]] =
            merge(st_q.seg_en[st_q.aw_addr[3:2]], 16'hFFFF, st_q.w_data, st_q.w_be);
        end
        AREA_PIXEL: begin
          ram_we = allow;
          set_fail = !allow;
        end
        default: begin
        end
      endcase
    end
    // A new failure wins over a clear arriving in the same cycle
    st_d.fail = set_fail || (st_q.fail && !clr_fail);

    if (axi_arvalid_i && axi_arready_o) begin
      st_d.ar_busy = 1'b1;
      st_d.ar_addr = axi_araddr_i;
    end
    if (st_q.r_valid && axi_rready_i) begin
      st_d.r_valid = 1'b0;
    end
    if (st_q.ar_busy) begin
      st_d.ar_busy = 1'b0;
      st_d.r_valid = 1'b1;
      st_d.r_resp = (ra == AREA_NONE) ? RESP_SLVERR : RESP_OKAY;
      case (ra)
        AREA_CONTROL: begin
          st_d.r_data = {16'h0000, st_q.control[15:6], st_q.fail, st_q.control[4:0]};
        end
        AREA_PUMP: begin
          st_d.r_data = {16'h0000, st_q.pump};
        end
        AREA_PHASE: begin
          st_d.r_data = {16'h0000, st_q.phase_cfg[15:6], st_q.active, allow,
                         st_q.phase_cfg[3:0]};
        end
        AREA_SEG: begin
          st_d.r_data = {16'h0000, st_q.seg_en[st_q.ar_addr[3:2]]};
        end
        AREA_PIXEL: begin
          st_d.r_data = {16'h0000, ram_word};
        end
        default: begin
          st_d.r_data = 32'h0000_0000;
        end
      endcase
    end

    // Oscillator inputs: three stages, a rising edge counts once stages two and three agree
    for (int k = 0; k < 3; k++) begin
      st_d.src_sync[k] = {st_q.src_sync[k][1:0], (k == 0) ? fast_rc_osc_i :
                          (k == 1) ? slow_rc_osc_i : crystal_osc_32k_i};
      if (st_q.src_sync[k][1] == st_q.src_sync[k][2]) begin
        st_d.src_lvl[k] = st_q.src_sync[k][2];
      end
      edges[k] = st_q.src_sync[k][1] && st_q.src_sync[k][2] && !st_q.src_lvl[k];
    end
    tick = st_q.control[CLK_LSB+1] ? edges[2] :
           st_q.control[CLK_LSB] ? edges[1] : edges[0];

    run = st_q.control[EN_BIT]
          && !(idle_mode_i && st_q.control[IDLE_BIT])
          && !(sleep_mode_i && st_q.control[SLEEP_BIT]);
    st_d.active = run;
    st_d.step = 1'b0;
    wrap = st_q.backplane_line >= mux;
    if (!run) begin
      st_d.pre_cnt = 4'h0;
      st_d.backplane_line = 3'h0;
      st_d.phase = 1'b0;
    end else begin
      if (tick) begin
        if (st_q.pre_cnt >= st_q.phase_cfg[PRE_LSB +: 4]) begin
          st_d.pre_cnt = 4'h0;
          st_d.step = 1'b1;
        end else begin
          st_d.pre_cnt = st_q.pre_cnt + 4'h1;
        end
      end
      if (st_q.step) begin
        if (st_q.phase_cfg[WAVE_BIT]) begin
          st_d.backplane_line = wrap ? 3'h0 : st_q.backplane_line + 3'h1;
          st_d.phase = wrap ? !st_q.phase : st_q.phase;
        end else begin
          st_d.phase = !st_q.phase;
          if (st_q.phase || st_q.backplane_line > mux) begin
            st_d.backplane_line = wrap ? 3'h0 : st_q.backplane_line + 3'h1;
          end
        end
      end
    end

    st_d.bias = bias_of(mux, st_q.phase_cfg[BIAS_MODE_SELECT_BIT]);
    st_d.pins = st_q.seg_en;
    for (int j = 0; j < 4; j++) begin
      if (mux >= 3'(4 + j)) begin
        st_d.pins[60+j] = 1'b0;
      end
    end
    for (int c = 0; c < 8; c++) begin
      st_d.com_lvl[c] = (st_q.active && c <= mux) ?
        com_level(st_q.bias, st_q.backplane_line == 3'(c), st_q.phase) : LVL_GND;
    end
    for (int g = 0; g < 64; g++) begin
      st_d.seg_lvl[g] = (st_q.active && st_q.pins[g]) ?
        seg_level(st_q.bias, ram_row[g], st_q.phase) : LVL_GND;
    end
    st_d.reg_on = st_q.pump[RCLK_LSB +: 2] != RCLK_OFF;
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= '0;
      st_q.pump <= PUMP_RST;
    end else begin
      st_q <= st_d;
    end
  end

  pixel_store #(
    .ROWS(8),
    .LANES(4),
    .LANE_W(16),
    .IDX_W(5),
    .ROW_W(3)
  ) pixel_store_i (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .wr_en_i(ram_we),
    .wr_index_i(st_q.aw_addr[6:2]),
    .wr_be_i(st_q.w_be),
    .wr_data_i(st_q.w_data),
    .rd_index_i(axi_araddr_i[6:2]),
    .rd_word_o(ram_word),
    .scan_row_i(st_d.backplane_line),
    .scan_row_o(ram_row)
  );

  assign axi_awready_o = !st_q.aw_full && !st_q.b_valid;
  assign axi_wready_o = !st_q.w_full && !st_q.b_valid;
  assign axi_bvalid_o = st_q.b_valid;
  assign axi_bresp_o = st_q.b_resp;
  assign axi_arready_o = !st_q.ar_busy && !st_q.r_valid;
  assign axi_rvalid_o = st_q.r_valid;
  assign axi_rdata_o = st_q.r_data;
  assign axi_rresp_o = st_q.r_resp;
  assign backplane_line_o = st_q.com_lvl;
  assign frontplane_line_o = st_q.seg_lvl;
  assign glyph_pin_enable_o = st_q.pins;
  assign bias_mode_o = st_q.bias;
  assign pump_enable_o = st_q.pump[EN_BIT];
  assign regulator_level_o = st_q.pump[5:3];
  assign third_bias_support_o = st_q.pump[2];
  assign regulator_clock_select_o = st_q.pump[RCLK_LSB +: 2];
  assign regulator_enable_o = st_q.reg_on;
  assign driver_active_o = st_q.active;

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence write_ready_s;
    st_q.aw_full && st_q.w_full && !st_q.b_valid;
  endsequence

  chk_enable_off: assert property (!st_q.control[EN_BIT] |=> !driver_active_o)
    else $error("Driver active while disabled");
  chk_idle_halt: assert property (
    idle_mode_i && st_q.control[IDLE_BIT] |=> !driver_active_o)
    else $error("Driver active in halted idle");
  chk_sleep_halt: assert property (
    sleep_mode_i && st_q.control[SLEEP_BIT] |=> !driver_active_o)
    else $error("Driver active in disabled sleep");
  chk_fail_set: assert property (
    write_ready_s ##0 set_fail |=> st_q.fail && axi_bvalid_o)
    else $error("Refused pixel write did not flag");
  chk_fail_hold: assert property (st_q.fail && !clr_fail |=> st_q.fail)
    else $error("Failure flag lost without clear");
  chk_com_bound: assert property (st_q.step |=> st_q.backplane_line <= $past(mux))
    else $error("Common index beyond selection");
  chk_bias_third: assert property (mux >= MUX_FOUR |=> bias_mode_o == BIAS_THIRD)
    else $error("Wrong bias for many commons");
  chk_pin_share: assert property (mux == MUX_FULL |=> glyph_pin_enable_o[63:60] == 4'h0)
    else $error("Shared pins still segments");
  chk_prescale_div: assert property (
    st_q.step |-> $past(st_q.pre_cnt) >= $past(st_q.phase_cfg[3:0]))
    else $error("Step before prescale count");
  chk_lines_quiet: assert property (!driver_active_o |=> backplane_line_o == 16'h0000)
    else $error("Commons driven while inactive");
  chk_regulator_off: assert property (
    st_q.pump[1:0] == RCLK_OFF |=> !regulator_enable_o)
    else $error("Regulator on with clock off");
endmodule // lcd_segment_driver_control

// >>> lcd_drv_pkg.sv
package lcd_drv_pkg;
  localparam logic [11:0] OFF_CONTROL = 12'h000;
  localparam logic [11:0] OFF_PUMP = 12'h004;
  localparam logic [11:0] OFF_PHASE = 12'h008;
  localparam logic [11:0] OFF_SEG_EN = 12'h010;
  localparam logic [11:0] OFF_PIXEL = 12'h080;
  localparam int EN_BIT = 15;
  localparam int IDLE_BIT = 13;
  localparam int SLEEP_BIT = 6;
  localparam int FAIL_BIT = 5;
  localparam int CLK_LSB = 3;
  localparam int MUX_LSB = 0;
  localparam int RCLK_LSB = 0;
  localparam int WAVE_BIT = 7;
  localparam int BIAS_MODE_SELECT_BIT = 6;
  localparam int ACTIVE_BIT = 5;
  localparam int ALLOW_BIT = 4;
  localparam int PRE_LSB = 0;
  localparam int BYTE_W = 8;
  localparam logic [15:0] CONTROL_MASK = 16'hA05F;
  localparam logic [15:0] PUMP_MASK = 16'h803F;
  localparam logic [15:0] PHASE_MASK = 16'h00CF;
  localparam logic [15:0] PUMP_RST = 16'h003C;
  localparam logic [2:0] MUX_THREE = 3'h2;
  localparam logic [2:0] MUX_FOUR = 3'h3;
  localparam logic [2:0] MUX_FULL = 3'h7;
  localparam logic [1:0] RCLK_OFF = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] LVL_GND = 2'h0;
  localparam logic [1:0] LVL_ONE = 2'h1;
  localparam logic [1:0] LVL_TWO = 2'h2;
  localparam logic [1:0] LVL_TOP = 2'h3;

  typedef enum logic [1:0] {BIAS_STATIC, BIAS_HALF, BIAS_THIRD} bias_type;
  typedef enum logic [2:0] {
    AREA_NONE, AREA_CONTROL, AREA_PUMP, AREA_PHASE, AREA_SEG, AREA_PIXEL
  } area_type;

  function automatic area_type area_of(logic [11:0] a);
    if (a[11:2] == OFF_CONTROL[11:2]) return AREA_CONTROL;
    if (a[11:2] == OFF_PUMP[11:2]) return AREA_PUMP;
    if (a[11:2] == OFF_PHASE[11:2]) return AREA_PHASE;
    if (a[11:4] == OFF_SEG_EN[11:4]) return AREA_SEG;
    if (a[11:7] == OFF_PIXEL[11:7]) return AREA_PIXEL;
    return AREA_NONE;
  endfunction

  function automatic bias_type bias_of(logic [2:0] mux, logic half_sel);
    if (mux == 3'h0) return BIAS_STATIC;
    if (mux <= MUX_THREE && half_sel) return BIAS_HALF;
    return BIAS_THIRD;
  endfunction
endpackage

// >>> pixel_store.sv
module pixel_store import lcd_drv_pkg::*; #(
  parameter int ROWS = 8,
  parameter int LANES = 4,
  parameter int LANE_W = 16,
  parameter int IDX_W = 5,
  parameter int ROW_W = 3
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic wr_en_i,
  input wire logic [IDX_W-1:0] wr_index_i,
  input wire logic [1:0] wr_be_i,
  input wire logic [LANE_W-1:0] wr_data_i,
  input wire logic [IDX_W-1:0] rd_index_i,
  output logic [LANE_W-1:0] rd_word_o,
  input wire logic [ROW_W-1:0] scan_row_i,
  output logic [LANES*LANE_W-1:0] scan_row_o
);
  typedef struct packed {
    logic [ROWS*LANES-1:0][LANE_W-1:0] mem;
    logic [LANE_W-1:0] word;
    logic [LANES*LANE_W-1:0] row;
  } store_type;

  store_type st_q;
  store_type st_d;

  // Word x sits in row x/4, lane x%4; lane 0 holds segments 0 to 15
  always_comb begin
    st_d = st_q;
    for (int b = 0; b < 2; b++) begin
      if (wr_en_i && wr_be_i[b]) begin
        st_d.mem[wr_index_i][b*BYTE_W +: BYTE_W] = wr_data_i[b*BYTE_W +: BYTE_W];
      end
    end
    st_d.word = st_q.mem[rd_index_i];
    st_d.row = st_q.mem[scan_row_i*LANES +: LANES];
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign rd_word_o = st_q.word;
  assign scan_row_o = st_q.row;
endmodule // pixel_store

// >>> lcd_glass_model.sv
module lcd_glass_model #(
  parameter int COMMON = 1,
  parameter int SEGMENT = 17
) (
  input wire logic clock_i,
  input wire logic clear_i,
  input wire logic [15:0] backplane_line_i,
  input wire logic [127:0] frontplane_line_i,
  output logic [1:0] peak_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] com_lvl;
  logic [1:0] seg_lvl;
  logic [1:0] diff;
  assign com_lvl = backplane_line_i[2*COMMON +: 2];
  assign seg_lvl = frontplane_line_i[2*SEGMENT +: 2];
  // The glass only sees the level difference across one pixel
  assign diff = (com_lvl > seg_lvl) ? com_lvl - seg_lvl : seg_lvl - com_lvl;
  always_ff @(posedge clock_i) begin
    if (clear_i) begin
      peak_o <= 2'h0;
    end else if (diff > peak_o) begin
      peak_o <= diff;
    end
  end
endmodule // lcd_glass_model

// >>> test_lcd_segment_driver_control.sv
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_count++; \
  $display("Error at %0t: got %h want %h", $time, (g), (e)); end end

module test_lcd_segment_driver_control import lcd_drv_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [11:0] a; logic [15:0] d; logic [15:0] q; logic [1:0] r;} row_type;
  logic clock_i, rst_n_i, awvalid, wvalid, bready, arvalid, rready;
  logic idle, sleep, fosc, crystal_osc_32k, xosc, clr, pump, third, renab, act;
  logic awready, wready, bvalid, arready, rvalid;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, bias, rclk, peak, r;
  logic [2:0] rlvl;
  logic [15:0] bp;
  logic [127:0] fp;
  logic [63:0] gpe;
  int err_count, checks_done, cyc;
  row_type rows [11] = '{
    '{OFF_CONTROL, 16'h6fff, 16'h205f, RESP_OKAY}, '{OFF_PUMP, 16'hffff, 16'h803f, RESP_OKAY},
    '{OFF_PUMP, 16'h7fc0, 16'h0000, RESP_OKAY}, '{OFF_PHASE, 16'hffbf, 16'h009f, RESP_OKAY},
    '{OFF_SEG_EN, 16'h1234, 16'h1234, RESP_OKAY}, '{12'h014, 16'h0002, 16'h0002, RESP_OKAY},
    '{12'h01c, 16'hffff, 16'hffff, RESP_OKAY}, '{OFF_PIXEL, 16'ha5a5, 16'ha5a5, RESP_OKAY},
    '{12'h0fc, 16'h5a5a, 16'h5a5a, RESP_OKAY}, '{12'h00c, 16'hffff, 16'h0000, RESP_SLVERR},
    '{12'h100, 16'hffff, 16'h0000, RESP_SLVERR}};
  logic [11:0] rst_a [5] = '{OFF_CONTROL, OFF_PUMP, OFF_PHASE, OFF_SEG_EN, 12'h094};
  logic [15:0] rst_v [5] = '{16'h0000, 16'h003c, 16'h0010, 16'h0000, 16'h0000};

  lcd_segment_driver_control lcd_segment_driver_control_i (
    .clock_i, .rst_n_i, .axi_awaddr_i(awaddr), .axi_awvalid_i(awvalid),
    .axi_awready_o(awready), .axi_wdata_i(wdata), .axi_wstrb_i(wstrb),
    .axi_wvalid_i(wvalid), .axi_wready_o(wready), .axi_bresp_o(bresp),
    .axi_bvalid_o(bvalid), .axi_bready_i(bready), .axi_araddr_i(araddr),
    .axi_arvalid_i(arvalid), .axi_arready_o(arready), .axi_rdata_o(rdata),
    .axi_rresp_o(rresp), .axi_rvalid_o(rvalid), .axi_rready_i(rready),
    .idle_mode_i(idle), .sleep_mode_i(sleep), .fast_rc_osc_i(fosc),
    .slow_rc_osc_i(crystal_osc_32k), .crystal_osc_32k_i(xosc), .backplane_line_o(bp),
    .frontplane_line_o(fp), .glyph_pin_enable_o(gpe), .bias_mode_o(bias),
    .pump_enable_o(pump), .regulator_level_o(rlvl), .third_bias_support_o(third),
    .regulator_clock_select_o(rclk), .regulator_enable_o(renab), .driver_active_o(act)
  );

  lcd_glass_model #(.COMMON(1), .SEGMENT(17)) lcd_glass_model_i (
    .clock_i, .clear_i(clr), .backplane_line_i(bp), .frontplane_line_i(fp), .peak_o(peak)
  );

  task automatic finish_test();
    $display("Checks %0d, errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [11:0] a, input logic [15:0] v, output logic [1:0] resp);
    @(posedge clock_i);
    awaddr <= a;
    wdata <= {16'h0000, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clock_i);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] resp);
    @(posedge clock_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clock_i);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    v = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  // Oscillators are slow levels; the hang limit also lives here
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    {xosc, crystal_osc_32k, fosc} <= {cyc[4], cyc[3], cyc[2]};
    if (cyc == 25000) begin
      err_count++;
      finish_test();
    end
  end

  initial begin
    {rst_n_i, awvalid, wvalid, bready, arvalid, rready, idle, sleep, clr} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    repeat (2) @(posedge clock_i);
    rst_n_i <= 1'b1;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d, r);
      `CHK(r, rows[i].r)
      rd(rows[i].a, d, r);
      `CHK(r, rows[i].r)
      `CHK(d, {16'h0000, rows[i].q})
    end
    // Only the upper byte lane of pixel word 0 is written
    wstrb <= 4'h2;
    wr(OFF_PIXEL, 16'h3c3c, r);
    wstrb <= 4'hf;
    rd(OFF_PIXEL, d, r);
    `CHK(d, 32'h0000_3ca5)
    wr(OFF_PUMP, 16'h8029, r);
    repeat (2) @(posedge clock_i);
    `CHK({pump, rlvl, third}, {1'b1, 3'h5, 1'b0})
    `CHK({rclk, renab}, {2'h1, 1'b1})
    wr(OFF_PUMP, 16'h0004, r);
    repeat (2) @(posedge clock_i);
    `CHK({third, rclk, renab}, {1'b1, 2'h0, 1'b0})
    `CHK(gpe[15:0], 16'h1234)
    for (int m = 0; m < 8; m++) begin
      for (int b = 0; b < 2; b++) begin
        if (b && (m == 0 || m > 2)) continue;
        wr(OFF_CONTROL, {13'h0000, m[2:0]}, r);
        wr(OFF_PHASE, {9'h000, b[0], 6'h00}, r);
        repeat (2) @(posedge clock_i);
        `CHK(bias, (m == 0) ? 2'h0 : (b ? 2'h1 : 2'h2))
        `CHK(gpe[63:60], 4'hf << ((m > 3) ? m - 3 : 0))
      end
    end
    for (int k = 0; k < 8; k++) begin
      if (k % 4 == 0) wr(OFF_CONTROL, k ? 16'h8000 : 16'ha040, r);
      @(posedge clock_i);
      idle <= k[0];
      sleep <= k[1];
      repeat (3) @(posedge clock_i);
      `CHK(act, (k > 3) || (!k[0] && !k[1]))
    end
    rd(OFF_PHASE, d, r);
    `CHK(d[5], 1'b1)
    idle <= 1'b0;
    sleep <= 1'b0;
    wr(OFF_CONTROL, 16'h0000, r);
    repeat (2) @(posedge clock_i);
    `CHK(act, 1'b0)
    // Probe pixel: common 1, segment 17, every clock source and both waveforms
    for (int k = 0; k < 4; k++) begin
      wr(OFF_CONTROL, 16'h0000, r);
      wr(12'h094, {14'h0000, k[1], 1'b0}, r);
      wr(OFF_PHASE, {8'h00, k[0], 7'h00}, r);
      wr(OFF_CONTROL, {8'h80, 3'h0, k[1:0], 3'h3}, r);
      clr <= 1'b1;
      @(posedge clock_i);
      clr <= 1'b0;
      repeat (600) @(posedge clock_i);
      `CHK(peak, k[1] ? 2'h3 : 2'h1)
    end
    wr(OFF_PHASE, 16'h000f, r);
    do rd(OFF_PHASE, d, r); while (!d[4]);
    do rd(OFF_PHASE, d, r); while (d[4]);
    wr(12'h094, 16'h0000, r);
    `CHK(r, RESP_OKAY)
    rd(OFF_CONTROL, d, r);
    `CHK(d[5], 1'b1)
    rd(12'h094, d, r);
    `CHK(d, 32'h0000_0002)
    wr(OFF_CONTROL, 16'h801b, r);
    rd(OFF_CONTROL, d, r);
    `CHK(d, 32'h0000_801b)
    @(posedge clock_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    `CHK({act, pump, rlvl, third, awready, arready}, 8'h3f)
    `CHK({bp, fp[63:0]}, 80'h0)
    rst_n_i <= 1'b1;
    foreach (rst_a[i]) begin
      rd(rst_a[i], d, r);
      `CHK(d, {16'h0000, rst_v[i]})
    end
    finish_test();
  end
endmodule // test_lcd_segment_driver_control
